/* verilog/mpgb_cfg.svh */
// Register map, field positions and reset values of the preamp control.
// Assumes an 8-bit register address and 16-bit register data.
//
// Functional notes
// - One gain per channel, shared by all of that channel's inputs.
// - New volumes wait; both apply when an update latch 1 is written.
// - Zero-cross off applies at once; on waits for next zero crossing.
// - Mute bit 1 mutes the channel and cuts it from the mixer.
// - Six-bit volume code maps linearly, -12 dB to 35.25 dB.
// - Volume resets to code 010000; mute, zero-cross, latch reset to 0.
// - Bias enable is one bit, seen at two register locations.
// - Bias enable 0 leaves the bias pin floating; 1 drives it.
// - Bias level select 0 picks 0.9, 1 picks 0.75 of supply.
// - Preamp enables are one bit each, seen at two locations.
`ifndef MPGB_CFG_SVH
`define MPGB_CFG_SVH

`define MPGB_ADDR_PWR_ONE 8'h08
`define MPGB_ADDR_PWR_TWO 8'h09
`define MPGB_ADDR_BIAS 8'h4A
`define MPGB_ADDR_LVOL 8'h50
`define MPGB_ADDR_RVOL 8'h51
`define MPGB_ADDR_STATUS 8'h52

`define MPGB_PWR_ONE_BIAS_EN 4
`define MPGB_PWR_TWO_LEFT_EN 8
`define MPGB_PWR_TWO_RIGHT_EN 9
`define MPGB_BIAS_EN 15
`define MPGB_BIAS_SEL 14
`define MPGB_VOL_EN 15
`define MPGB_VOL_MUTE 14
`define MPGB_VOL_ZC 13
`define MPGB_VOL_VU 8
`define MPGB_VOL_MSB 7
`define MPGB_VOL_LSB 2

`define MPGB_STAT_LEFT_LSB 0
`define MPGB_STAT_RIGHT_LSB 6
`define MPGB_STAT_LEFT_WAIT 12
`define MPGB_STAT_RIGHT_WAIT 13

`define MPGB_VOL_RESET 6'h10
`define MPGB_BIT_RESET 1'h0

`endif

/* verilog/mpgb_pkg.sv */
// Types shared by the preamp control modules.
// Assumes nothing beyond the constants header.
`default_nettype none

package mpgb_pkg;
  typedef enum logic [0:0] {
    MPGB_APPLIED = 1'h0,
    MPGB_WAIT_ZC = 1'h1
  } mpgb_apply_t;
  typedef logic [5:0] mpgb_vol_t;
endpackage : mpgb_pkg

`default_nettype wire

/* verilog/mpgb_gain_apply.sv */
// One channel's gain applier: takes a target on an update pulse and
// applies it at once or at the next zero crossing.
// Assumes update and zero_cross are one-cycle pulses on clk.
`include "mpgb_cfg.svh"
`default_nettype none

module mpgb_gain_apply
  import mpgb_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic update,
  input wire logic zc_enable,
  input wire logic zero_cross,
  input wire mpgb_vol_t target,
  output mpgb_vol_t gain_q,
  output logic waiting_q
);
  mpgb_apply_t state_q, state_d;
  mpgb_vol_t gain_d, target_q, target_d;

  always_comb begin
    state_d = state_q;
    gain_d = gain_q;
    target_d = target_q;
    unique case (state_q)
      MPGB_APPLIED: begin
        if (update && !zc_enable) begin
          gain_d = target;
        end else if (update) begin
          target_d = target;
          state_d = MPGB_WAIT_ZC;
        end
      end
      MPGB_WAIT_ZC: begin
        // A fresh update restarts the wait; crossing must follow it
        if (update && zc_enable) begin
          target_d = target;
        end else if (update) begin
          gain_d = target;
          state_d = MPGB_APPLIED;
        end else if (zero_cross || !zc_enable) begin
          gain_d = target_q;
          state_d = MPGB_APPLIED;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= MPGB_APPLIED;
      gain_q <= `MPGB_VOL_RESET;
      target_q <= `MPGB_VOL_RESET;
    end else begin
      state_q <= state_d;
      gain_q <= gain_d;
      target_q <= target_d;
    end
  end

  assign waiting_q = (state_q == MPGB_WAIT_ZC);

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_zc_apply;
    waiting_q && zc_enable && zero_cross && !update |=>
      !waiting_q && gain_q == $past(target_q);
  endproperty
  a_zc_apply: assert property (p_zc_apply)
    else $error("pending gain not applied at zero crossing");

  property p_zc_hold;
    waiting_q && zc_enable && !zero_cross && !update |=> $stable(gain_q);
  endproperty
  a_zc_hold: assert property (p_zc_hold)
    else $error("gain changed before zero crossing");

  c_zc_wait: cover property (update && zc_enable ##[1:20] zero_cross);
endmodule : mpgb_gain_apply

`default_nettype wire

/* verilog/mpgb_ctrl.sv */
// Microphone preamp gain and bias control register bank.
// Assumes a single-cycle register port on clk with read data one cycle
// later, and asynchronous zero-cross sign inputs from the analog side.
//
// Design decision made here: the address-and-strobe port.
`include "mpgb_cfg.svh"
`default_nettype none

module mpgb_ctrl
  import mpgb_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rdata_q,
  input wire logic left_sign_in,
  input wire logic right_sign_in,
  output mpgb_vol_t left_preamp_volume,
  output mpgb_vol_t right_preamp_volume,
  output logic left_preamp_mute_q,
  output logic right_preamp_mute_q,
  output logic left_preamp_enable_q,
  output logic right_preamp_enable_q,
  output logic bias_output_enable_q,
  output logic bias_level_select_q,
  output logic bias_output_pin_o,
  output logic bias_output_pin_oe
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // Stored control bits
  mpgb_vol_t left_pend_q, left_pend_d, right_pend_q, right_pend_d;
  logic left_mute_d, right_mute_d;
  logic left_zc_q, left_zc_d, right_zc_q, right_zc_d;
  logic left_en_d, right_en_d;
  logic bias_en_d, bias_sel_d;
  logic bias_pin_o_d;
  logic [15:0] rdata_d;
  logic vu_write;
  logic left_wait, right_wait;

  // Zero-cross sign synchronisers and edge detect
  logic [1:0] left_sync_q, left_sync_d, right_sync_q, right_sync_d;
  logic left_last_q, left_last_d, right_last_q, right_last_d;
  logic left_zc_pulse, right_zc_pulse;

  always_comb begin
    left_sync_d = {left_sync_q[0], left_sign_in};
    right_sync_d = {right_sync_q[0], right_sign_in};
    left_last_d = left_sync_q[1];
    right_last_d = right_sync_q[1];
  end

  // No reset: the flops follow the pins through reset, so a pin that
  // idles high gives no false crossing once reset is released.
  always_ff @(posedge clk) begin
    left_sync_q <= left_sync_d;
    right_sync_q <= right_sync_d;
    left_last_q <= left_last_d;
    right_last_q <= right_last_d;
  end

  // Each sign change is one crossing
  assign left_zc_pulse = left_sync_q[1] ^ left_last_q;
  assign right_zc_pulse = right_sync_q[1] ^ right_last_q;

  // Write side
  assign vu_write = wr_stb && wdata[`MPGB_VOL_VU] &&
    (hit(addr, `MPGB_ADDR_LVOL) || hit(addr, `MPGB_ADDR_RVOL));

  always_comb begin
    left_pend_d = left_pend_q;
    right_pend_d = right_pend_q;
    left_mute_d = left_preamp_mute_q;
    right_mute_d = right_preamp_mute_q;
    left_zc_d = left_zc_q;
    right_zc_d = right_zc_q;
    left_en_d = left_preamp_enable_q;
    right_en_d = right_preamp_enable_q;
    bias_en_d = bias_output_enable_q;
    bias_sel_d = bias_level_select_q;
    if (wr_stb) begin
      if (hit(addr, `MPGB_ADDR_PWR_ONE)) begin
        bias_en_d = wdata[`MPGB_PWR_ONE_BIAS_EN];
      end
      if (hit(addr, `MPGB_ADDR_BIAS)) begin
        bias_en_d = wdata[`MPGB_BIAS_EN];
        bias_sel_d = wdata[`MPGB_BIAS_SEL];
      end
      if (hit(addr, `MPGB_ADDR_PWR_TWO)) begin
        left_en_d = wdata[`MPGB_PWR_TWO_LEFT_EN];
        right_en_d = wdata[`MPGB_PWR_TWO_RIGHT_EN];
      end
      if (hit(addr, `MPGB_ADDR_LVOL)) begin
        left_en_d = wdata[`MPGB_VOL_EN];
        left_mute_d = wdata[`MPGB_VOL_MUTE];
        left_zc_d = wdata[`MPGB_VOL_ZC];
        left_pend_d = wdata[`MPGB_VOL_MSB:`MPGB_VOL_LSB];
      end
      if (hit(addr, `MPGB_ADDR_RVOL)) begin
        right_en_d = wdata[`MPGB_VOL_EN];
        right_mute_d = wdata[`MPGB_VOL_MUTE];
        right_zc_d = wdata[`MPGB_VOL_ZC];
        right_pend_d = wdata[`MPGB_VOL_MSB:`MPGB_VOL_LSB];
      end
    end
    // Pin drives only while enabled, otherwise left floating
    bias_pin_o_d = bias_en_d;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      left_pend_q <= `MPGB_VOL_RESET;
      right_pend_q <= `MPGB_VOL_RESET;
      left_preamp_mute_q <= `MPGB_BIT_RESET;
      right_preamp_mute_q <= `MPGB_BIT_RESET;
      left_zc_q <= `MPGB_BIT_RESET;
      right_zc_q <= `MPGB_BIT_RESET;
      left_preamp_enable_q <= `MPGB_BIT_RESET;
      right_preamp_enable_q <= `MPGB_BIT_RESET;
      bias_output_enable_q <= `MPGB_BIT_RESET;
      bias_level_select_q <= `MPGB_BIT_RESET;
      bias_output_pin_o <= `MPGB_BIT_RESET;
      bias_output_pin_oe <= `MPGB_BIT_RESET;
    end else begin
      left_pend_q <= left_pend_d;
      right_pend_q <= right_pend_d;
      left_preamp_mute_q <= left_mute_d;
      right_preamp_mute_q <= right_mute_d;
      left_zc_q <= left_zc_d;
      right_zc_q <= right_zc_d;
      left_preamp_enable_q <= left_en_d;
      right_preamp_enable_q <= right_en_d;
      bias_output_enable_q <= bias_en_d;
      bias_level_select_q <= bias_sel_d;
      bias_output_pin_o <= bias_pin_o_d;
      bias_output_pin_oe <= bias_pin_o_d;
    end
  end

  // The update pulse carries the value written in the same cycle, so a
  // write with the latch bit set applies its own volume too.
  // Each channel has one gain output for all its inputs
  mpgb_gain_apply u_left (
    .clk(clk),
    .reset(reset),
    .update(vu_write),
    .zc_enable(left_zc_d),
    .zero_cross(left_zc_pulse),
    .target(left_pend_d),
    .gain_q(left_preamp_volume),
    .waiting_q(left_wait)
  );

  mpgb_gain_apply u_right (
    .clk(clk),
    .reset(reset),
    .update(vu_write),
    .zc_enable(right_zc_d),
    .zero_cross(right_zc_pulse),
    .target(right_pend_d),
    .gain_q(right_preamp_volume),
    .waiting_q(right_wait)
  );

  // Read side; the latch bit is a trigger and reads back as 0
  always_comb begin
    rdata_d = 16'h0000;
    if (rd_stb) begin
      if (hit(addr, `MPGB_ADDR_PWR_ONE)) begin
        rdata_d[`MPGB_PWR_ONE_BIAS_EN] = bias_output_enable_q;
      end
      if (hit(addr, `MPGB_ADDR_BIAS)) begin
        rdata_d[`MPGB_BIAS_EN] = bias_output_enable_q;
        rdata_d[`MPGB_BIAS_SEL] = bias_level_select_q;
      end
      if (hit(addr, `MPGB_ADDR_PWR_TWO)) begin
        rdata_d[`MPGB_PWR_TWO_LEFT_EN] = left_preamp_enable_q;
        rdata_d[`MPGB_PWR_TWO_RIGHT_EN] = right_preamp_enable_q;
      end
      if (hit(addr, `MPGB_ADDR_LVOL)) begin
        rdata_d[`MPGB_VOL_EN] = left_preamp_enable_q;
        rdata_d[`MPGB_VOL_MUTE] = left_preamp_mute_q;
        rdata_d[`MPGB_VOL_ZC] = left_zc_q;
        rdata_d[`MPGB_VOL_MSB:`MPGB_VOL_LSB] = left_pend_q;
      end
      if (hit(addr, `MPGB_ADDR_RVOL)) begin
        rdata_d[`MPGB_VOL_EN] = right_preamp_enable_q;
        rdata_d[`MPGB_VOL_MUTE] = right_preamp_mute_q;
        rdata_d[`MPGB_VOL_ZC] = right_zc_q;
        rdata_d[`MPGB_VOL_MSB:`MPGB_VOL_LSB] = right_pend_q;
      end
      if (hit(addr, `MPGB_ADDR_STATUS)) begin
        rdata_d[`MPGB_STAT_LEFT_LSB +: 6] = left_preamp_volume;
        rdata_d[`MPGB_STAT_RIGHT_LSB +: 6] = right_preamp_volume;
        rdata_d[`MPGB_STAT_LEFT_WAIT] = left_wait;
        rdata_d[`MPGB_STAT_RIGHT_WAIT] = right_wait;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_vu_hold;
    wr_stb && hit(addr, `MPGB_ADDR_LVOL) && !wdata[`MPGB_VOL_VU] &&
      !left_wait |=> $stable(left_preamp_volume);
  endproperty
  a_vu_hold: assert property (p_vu_hold)
    else $error("left gain moved without update latch");

  property p_vu_both;
    vu_write && !left_zc_d && !right_zc_d |=>
      left_preamp_volume == $past(left_pend_d) &&
      right_preamp_volume == $past(right_pend_d);
  endproperty
  a_vu_both: assert property (p_vu_both)
    else $error("update latch did not apply both gains");

  property p_zc_defer;
    vu_write && left_zc_d |=> left_wait ##0 $stable(left_preamp_volume);
  endproperty
  a_zc_defer: assert property (p_zc_defer)
    else $error("zero-cross mode did not defer left gain");

  property p_mute;
    wr_stb && hit(addr, `MPGB_ADDR_RVOL) |=>
      right_preamp_mute_q == $past(wdata[`MPGB_VOL_MUTE]);
  endproperty
  a_mute: assert property (p_mute)
    else $error("right mute does not follow write");

  property p_reset_vals;
    $fell(reset) |-> left_preamp_volume == `MPGB_VOL_RESET &&
      right_preamp_volume == `MPGB_VOL_RESET && !left_preamp_mute_q;
  endproperty
  a_reset_vals: assert property (@(posedge clk) p_reset_vals)
    else $error("wrong values after reset");

  property p_bias_alias;
    rd_stb && hit(addr, `MPGB_ADDR_PWR_ONE) |=>
      rdata_q[`MPGB_PWR_ONE_BIAS_EN] == bias_output_enable_q ||
      $past(wr_stb);
  endproperty
  a_bias_alias: assert property (p_bias_alias)
    else $error("bias enable alias reads differently");

  property p_bias_pin;
    wr_stb && hit(addr, `MPGB_ADDR_BIAS) |=>
      bias_output_pin_oe == $past(wdata[`MPGB_BIAS_EN]);
  endproperty
  a_bias_pin: assert property (p_bias_pin)
    else $error("bias pin drive does not follow enable");

  property p_bias_sel;
    wr_stb && hit(addr, `MPGB_ADDR_BIAS) |=>
      bias_level_select_q == $past(wdata[`MPGB_BIAS_SEL]);
  endproperty
  a_bias_sel: assert property (p_bias_sel)
    else $error("bias level select not stored");

  property p_en_alias;
    wr_stb && hit(addr, `MPGB_ADDR_PWR_TWO) |=>
      left_preamp_enable_q == $past(wdata[`MPGB_PWR_TWO_LEFT_EN]);
  endproperty
  a_en_alias: assert property (p_en_alias)
    else $error("left enable alias write lost");

  property p_bias_wr_one;
    wr_stb && hit(addr, `MPGB_ADDR_PWR_ONE) |=>
      bias_output_enable_q == $past(wdata[`MPGB_PWR_ONE_BIAS_EN]);
  endproperty
  a_bias_wr_one: assert property (p_bias_wr_one)
    else $error("bias enable write through power register lost");

  property p_en_vol;
    wr_stb && hit(addr, `MPGB_ADDR_RVOL) |=>
      right_preamp_enable_q == $past(wdata[`MPGB_VOL_EN]);
  endproperty
  a_en_vol: assert property (p_en_vol)
    else $error("right enable write through volume register lost");

  property p_mute_left;
    wr_stb && hit(addr, `MPGB_ADDR_LVOL) |=>
      left_preamp_mute_q == $past(wdata[`MPGB_VOL_MUTE]);
  endproperty
  a_mute_left: assert property (p_mute_left)
    else $error("left mute does not follow write");

  property p_pend_vol;
    wr_stb && hit(addr, `MPGB_ADDR_LVOL) |=>
      left_pend_q == $past(wdata[`MPGB_VOL_MSB:`MPGB_VOL_LSB]);
  endproperty
  a_pend_vol: assert property (p_pend_vol)
    else $error("left pending volume not stored");

  c_vu_now: cover property (vu_write && !left_zc_d);
  c_bias_on: cover property ($rose(bias_output_pin_oe));
  c_both_wait: cover property (left_wait && right_wait);

endmodule : mpgb_ctrl

`default_nettype wire

/* testbench/mpgb_ctrl_tb.sv */
// Self-checking bench for the preamp gain and bias register bank.
// Assumes the register port, sign inputs and outputs of mpgb_ctrl only.
`default_nettype none

module mpgb_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic left_sign_in = 1'b0;
  logic right_sign_in = 1'b0;
  logic [15:0] rdata_q;
  logic [5:0] lvol, rvol;
  logic lmute, rmute, len, ren, ben, bsel, bpin, boe;
  int failures = 0;
  int cmp_count = 0;
  // Bench model of the register state
  logic m_len = 0, m_ren = 0, m_lmu = 0, m_rmu = 0, m_lzc = 0, m_rzc = 0;
  logic m_ben = 0, m_sel = 0, m_lw = 0, m_rw = 0;
  logic [5:0] m_lp = 6'h10, m_rp = 6'h10, m_la = 6'h10, m_ra = 6'h10;
  logic [7:0] amap [7] = '{8'h08, 8'h09, 8'h4A, 8'h50, 8'h51, 8'h52, 8'h7F};

  always #20 clk = ~clk;

  mpgb_ctrl u_mpgb_ctrl (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q),
    .left_sign_in(left_sign_in), .right_sign_in(right_sign_in),
    .left_preamp_volume(lvol), .right_preamp_volume(rvol),
    .left_preamp_mute_q(lmute), .right_preamp_mute_q(rmute),
    .left_preamp_enable_q(len), .right_preamp_enable_q(ren),
    .bias_output_enable_q(ben), .bias_level_select_q(bsel),
    .bias_output_pin_o(bpin), .bias_output_pin_oe(boe)
  );

  function automatic logic [15:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h08: return {11'h000, m_ben, 4'h0};
      8'h09: return {6'h00, m_ren, m_len, 8'h00};
      8'h4A: return {m_ben, m_sel, 14'h0000};
      8'h50: return {m_len, m_lmu, m_lzc, 5'h00, m_lp, 2'h0};
      8'h51: return {m_ren, m_rmu, m_rzc, 5'h00, m_rp, 2'h0};
      8'h52: return {2'h0, m_rw, m_lw, m_ra, m_la};
      default: return 16'h0000;
    endcase
  endfunction : exp_rd

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    case (a)
      8'h08: m_ben = d[4];
      8'h09: {m_ren, m_len} = d[9:8];
      8'h4A: {m_ben, m_sel} = d[15:14];
      8'h50: {m_len, m_lmu, m_lzc, m_lp} = {d[15:13], d[7:2]};
      8'h51: {m_ren, m_rmu, m_rzc, m_rp} = {d[15:13], d[7:2]};
      default: ;
    endcase
    if ((a == 8'h50 || a == 8'h51) && d[8]) begin
      m_lw = m_lzc;
      m_rw = m_rzc;
    end
    // Cleared zero-cross releases a waiting channel at once
    if ((a == 8'h50 || a == 8'h51) && d[8] || !m_lzc && m_lw) begin
      if (!m_lzc) m_la = m_lp;
      if (!m_lzc) m_lw = 1'b0;
    end
    if ((a == 8'h50 || a == 8'h51) && d[8] || !m_rzc && m_rw) begin
      if (!m_rzc) m_ra = m_rp;
      if (!m_rzc) m_rw = 1'b0;
    end
  endtask : wr

  task automatic rd_chk(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    chk(rdata_q, exp_rd(a));
    @(negedge clk);
    chk(rdata_q, 16'h0000);
  endtask : rd_chk

  task automatic chk_all();
    @(negedge clk);
    chk({10'h000, lvol}, {10'h000, m_la});
    chk({10'h000, rvol}, {10'h000, m_ra});
    chk({lmute, rmute}, {m_lmu, m_rmu});
    chk({len, ren}, {m_len, m_ren});
    chk({ben, bsel}, {m_ben, m_sel});
    chk({bpin, boe}, {m_ben, m_ben});
    foreach (amap[i]) rd_chk(amap[i]);
  endtask : chk_all

  task automatic wait_left(input logic [5:0] v);
    int n;
    n = 0;
    while (lvol !== v && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk({10'h000, lvol}, {10'h000, v});
    m_la = v;
    m_lw = 1'b0;
  endtask : wait_left

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    wrap_up();
  end

  initial begin
    logic [15:0] d;
    void'($urandom(22));
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    chk_all();
    // Pending left value must not apply without the latch
    wr(8'h50, 16'h00FC);
    chk_all();
    wr(8'h51, 16'h0104);
    chk_all();
    wr(8'h08, 16'h0010);
    chk_all();
    wr(8'h4A, 16'h4000);
    chk_all();
    wr(8'h09, 16'h0300);
    wr(8'h7F, 16'hFFFF);
    chk_all();
    for (int i = 0; i < 30; i++) begin
      d = 16'($urandom());
      d[13] = 1'b0;
      wr(amap[$urandom_range(0, 6)], d);
      chk_all();
    end
    // Crossing before the latch write must not release the gain
    wr(8'h50, 16'h20A8);
    @(posedge clk);
    left_sign_in <= ~left_sign_in;
    repeat (6) @(posedge clk);
    wr(8'h51, 16'h0114);
    repeat (6) @(posedge clk);
    chk_all();
    @(posedge clk);
    left_sign_in <= ~left_sign_in;
    wait_left(6'h2A);
    chk_all();
    // Clearing zero-cross while waiting applies at once
    wr(8'h50, 16'h21FC);
    chk_all();
    wr(8'h50, 16'h00FC);
    chk_all();
    // Both channels wait on their own zero-cross, then both release
    wr(8'h50, 16'h2064);
    wr(8'h51, 16'h2134);
    chk_all();
    @(posedge clk);
    {left_sign_in, right_sign_in} <= ~{left_sign_in, right_sign_in};
    repeat (5) @(posedge clk);
    {m_la, m_ra, m_lw, m_rw} = {m_lp, m_rp, 2'b00};
    chk_all();
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    {m_len, m_ren, m_lmu, m_rmu, m_lzc, m_rzc} = 6'h00;
    {m_ben, m_sel, m_lw, m_rw} = 4'h0;
    {m_lp, m_rp, m_la, m_ra} = {4{6'h10}};
    chk_all();
    wrap_up();
  end
endmodule : mpgb_ctrl_tb

`default_nettype wire
